// >>> design/ebsc_fifo.sv
// Request FIFO with parameterised width and depth.
`timescale 1ns/1ps
`default_nettype none
module ebsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and reset.
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    // Filling side.
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Draining side.
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    // Storage entries and pointers, one bit wider for full detection.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             do_push;
    logic             do_pop;

    // Full when pointers differ only in the wrap bit; empty when equal.
    assign o_in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                           (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign o_out_valid = (wr_ptr != rd_ptr);
    assign o_out_data  = mem[rd_ptr[AW-1:0]];
    assign do_push     = i_in_valid && o_in_ready;
    assign do_pop      = o_out_valid && i_out_ready;

    // Pointer advance.
    always_comb begin
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    // Pointer registers.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Entry storage; one generate loop writes the addressed entry.
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge i_clk_sys) begin
            if (do_push && (wr_ptr[AW-1:0] == AW'(g))) begin
                mem[g] <= i_in_data;
            end
        end
    end
endmodule : ebsc_fifo
`default_nettype wire

// >>> design/ebsc_pkg.sv
// Package with constants and types of the external bus strobe control block.
package ebsc_pkg;
    // Widths of the internal request path and of the external pins.
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int SPACE_W    = 2;
    localparam int SEL_W      = 4;
    // Request word layout: write flag, word flag, space, address, data.
    localparam int REQ_W      = 1 + 1 + SPACE_W + ADDR_W + DATA_W;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW    = 5;
    // Timing of one access, in system clock cycles at 50 ns each.
    localparam int CLK_PERIOD_NS = 50;
    localparam int ALE_TIME_NS   = 50;
    localparam int ALE_CYCLES    = (ALE_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int STB_TIME_NS   = 100;
    localparam int STB_CYCLES    = (STB_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam logic [1:0] CNT_ONE = 2'h1;
    // Inactive level of the bus strobes.
    localparam logic STROBE_IDLE = 1'b1;
    // Bus cycle states.
    typedef enum logic [2:0] {
        EBSC_IDLE,
        EBSC_ADDR,
        EBSC_STROBE,
        EBSC_WAIT,
        EBSC_HOLD
    } ebsc_state_type;
endpackage : ebsc_pkg

// >>> design/ebsc_top.sv
// External bus strobe control: request FIFO, bus sequencer and strobes.
// What this block does
// R1: Separate scheme writes even bytes on low strobe.
// R2: Separate scheme writes odd bytes on high strobe.
// R3: Read strobe low while reading external data.
// R4: Single scheme writes with common write strobe.
// R5: Single scheme drives upper enable low odd.
// R6: Single scheme suits an eight-bit data bus.
// R7: Mode input selects which strobe scheme applies.
// R8: Hold request low stops new bus cycles.
// R9: Release grant low in hold, else high.
// R10: Address latch strobe pulses for external latch.
// R11: Ready low keeps the cycle from completing.
// R12: Eight-bit mode shares low lines address/data.
// R13: Four space selects name the target space.
// R14: Strobes inactive high outside cycles, reset, hold.
// R15: Whole wait cycles while ready low.
`timescale 1ns/1ps
`default_nettype none
module ebsc_top (
    // Clock and reset.
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst_n,
    // Configuration levels from the core.
    input  wire logic                          i_single_strobe_mode,
    input  wire logic                          i_mux8_mode,
    // Access requests from the core.
    input  wire logic                          i_req_valid,
    output logic                               o_req_ready,
    input  wire logic                          i_req_write,
    input  wire logic                          i_req_word,
    input  wire logic [ebsc_pkg::SPACE_W-1:0]  i_req_space,
    input  wire logic [ebsc_pkg::ADDR_W-1:0]   i_req_addr,
    input  wire logic [ebsc_pkg::DATA_W-1:0]   i_req_wdata,
    // Read answers to the core.
    output logic                               o_rsp_valid,
    output logic [ebsc_pkg::DATA_W-1:0]        o_rsp_rdata,
    // External bus pins.
    output logic [ebsc_pkg::ADDR_W-1:0]        o_addr,
    input  wire logic [ebsc_pkg::DATA_W-1:0]   i_data,
    output logic [ebsc_pkg::DATA_W-1:0]        o_data,
    output logic                               o_data_oe,
    output logic [ebsc_pkg::SEL_W-1:0]         o_space_select_lines_n,
    output logic                               o_address_latch_strobe,
    output logic                               o_low_byte_write_strobe_n,
    output logic                               o_high_byte_write_strobe_n,
    output logic                               o_read_strobe_n,
    input  wire logic                          i_bus_release_request_n,
    output logic                               o_bus_release_grant_n,
    input  wire logic                          i_ready_n
);
    import ebsc_pkg::*;

    // Pin synchronisers; stage one is read only by stage two.
    logic hold_s1;
    logic hold_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;

    // Sequencer state and the latched request.
    ebsc_state_type    state;
    ebsc_state_type    next_state;
    logic [1:0]        cnt;
    logic [1:0]        next_cnt;
    logic [REQ_W-1:0]  cur;
    logic [REQ_W-1:0]  next_cur;

    // Registered pin and answer values.
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] next_addr_q;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] next_dout_q;
    logic              oe_q;
    logic              next_oe_q;
    logic [SEL_W-1:0]  sel_q;
    logic [SEL_W-1:0]  next_sel_q;
    logic              ale_q;
    logic              next_ale_q;
    logic              wrl_q;
    logic              next_wrl_q;
    logic              wrh_q;
    logic              next_wrh_q;
    logic              rd_q;
    logic              next_rd_q;
    logic              grant_q;
    logic              next_grant_q;
    logic              rsp_v;
    logic              next_rsp_v;
    logic [DATA_W-1:0] rsp_d;
    logic [DATA_W-1:0] next_rsp_d;
    logic              rsp_pend;      // Read ended; synced data is due.
    logic              next_rsp_pend; // Two-flop data lags the pins.

    // FIFO draining side.
    logic              f_valid;
    logic              f_ready;
    logic [REQ_W-1:0]  f_data;

    // Fields of the current request.
    logic              c_write;
    logic              c_word;
    logic [SPACE_W-1:0] c_space;
    logic [ADDR_W-1:0] c_addr;
    logic [DATA_W-1:0] c_wdata;
    logic              c_odd;
    assign {c_write, c_word, c_space, c_addr, c_wdata} = cur;
    assign c_odd = c_addr[0];

    // Requests queue here so the core can run ahead of slow memory.
    ebsc_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (i_req_valid),
        .o_in_ready  (o_req_ready),
        .i_in_data   ({i_req_write, i_req_word, i_req_space,
                       i_req_addr, i_req_wdata}),
        .o_out_valid (f_valid),
        .i_out_ready (f_ready),
        .o_out_data  (f_data)
    );

    // The sequencer only pops when it may start a cycle.
    assign f_ready = (state == EBSC_IDLE) && hold_s2;

    // Two-flop synchronisers on asynchronous pins.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            hold_s1 <= 1'b1;
            hold_s2 <= 1'b1;
            rdy_s1  <= 1'b1;
            rdy_s2  <= 1'b1;
            din_s1  <= '0;
            din_s2  <= '0;
        end else begin
            hold_s1 <= i_bus_release_request_n;
            hold_s2 <= hold_s1;
            rdy_s1  <= i_ready_n;
            rdy_s2  <= rdy_s1;
            din_s1  <= i_data;
            din_s2  <= din_s1;
        end
    end

    // Next-state logic of the bus sequencer and its pins.
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_cur     = cur;
        next_addr_q  = addr_q;
        next_dout_q  = dout_q;
        next_oe_q    = 1'b0;
        next_sel_q   = {SEL_W{STROBE_IDLE}};
        next_ale_q   = 1'b0;
        next_wrl_q   = STROBE_IDLE; // [R14]
        next_wrh_q   = STROBE_IDLE; // [R14]
        next_rd_q    = STROBE_IDLE; // [R14]
        next_grant_q = STROBE_IDLE; // [R9]
        next_rsp_pend = 1'b0;
        next_rsp_v   = rsp_pend; // [R3]
        next_rsp_d   = rsp_pend ? din_s2 : rsp_d; // [R3]
        case (state)
            EBSC_IDLE: begin
                // Hold takes priority over queued work.
                if (!hold_s2) begin
                    next_state   = EBSC_HOLD; // [R8]
                    next_grant_q = 1'b0; // [R9]
                end else if (f_valid) begin
                    next_cur    = f_data;
                    next_addr_q = f_data[DATA_W +: ADDR_W];
                    next_cnt    = 2'(ALE_CYCLES);
                    next_ale_q  = 1'b1; // [R10]
                    // In 8-bit multiplexed mode the low lines carry
                    // the address during the latch phase.
                    if (i_mux8_mode) begin
                        next_dout_q = {{(DATA_W-8){1'b0}},
                                       f_data[DATA_W +: 8]}; // [R12]
                        next_oe_q   = 1'b1; // [R12]
                    end
                    next_sel_q  = ~(SEL_W'(1) <<
                                    f_data[DATA_W+ADDR_W +: SPACE_W]);
                    next_state  = EBSC_ADDR; // [R13]
                end
            end
            EBSC_ADDR: begin
                next_sel_q = sel_q; // [R13]
                next_ale_q = (cnt != CNT_ONE); // [R10]
                next_oe_q  = oe_q && (cnt != CNT_ONE);
                if (cnt == CNT_ONE) begin
                    next_cnt    = 2'(STB_CYCLES);
                    next_state  = EBSC_STROBE;
                    // Low lines switch from address to data.
                    next_dout_q = c_wdata; // [R12]
                    next_oe_q   = c_write;
                    next_rd_q   = c_write; // [R3]
                    if (i_single_strobe_mode) begin
                        next_wrl_q = !c_write; // [R4] [R7]
                        next_wrh_q = !(c_word || c_odd); // [R5]
                    end else begin
                        next_wrl_q = !(c_write && (c_word || !c_odd)); // [R1]
                        next_wrh_q = !(c_write && (c_word || c_odd)); // [R2]
                    end
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            EBSC_STROBE, EBSC_WAIT: begin
                next_sel_q = sel_q;
                next_wrl_q = wrl_q;
                next_wrh_q = wrh_q;
                next_rd_q  = rd_q;
                next_oe_q  = oe_q;
                if (cnt != CNT_ONE) begin
                    next_cnt = cnt - 1'b1;
                end else if (!rdy_s2) begin
                    next_state = EBSC_WAIT; // [R11] [R15]
                end else begin
                    // Ready high: end the access this cycle.
                    next_state = EBSC_IDLE; // [R15]
                    next_wrl_q = STROBE_IDLE; // [R14]
                    next_wrh_q = STROBE_IDLE;
                    next_rd_q  = STROBE_IDLE;
                    next_oe_q  = 1'b0;
                    next_sel_q = {SEL_W{STROBE_IDLE}};
                    next_rsp_pend = !c_write; // [R3]
                end
            end
            EBSC_HOLD: begin
                // Strobes stay high and the grant low until release.
                next_grant_q = hold_s2; // [R9]
                if (hold_s2) begin
                    next_state = EBSC_IDLE; // [R8]
                end
            end
            default: begin
                next_state = EBSC_IDLE;
            end
        endcase
    end

    // Sequencer registers; reset forces every strobe inactive.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state   <= EBSC_IDLE;
            cnt     <= '0;
            cur     <= '0;
            addr_q  <= '0;
            dout_q  <= '0;
            oe_q    <= 1'b0;
            sel_q   <= {SEL_W{STROBE_IDLE}};
            ale_q   <= 1'b0;
            wrl_q   <= STROBE_IDLE; // [R14]
            wrh_q   <= STROBE_IDLE; // [R14]
            rd_q    <= STROBE_IDLE; // [R14]
            grant_q <= STROBE_IDLE;
            rsp_v   <= 1'b0;
            rsp_d   <= '0;
            rsp_pend <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            cur     <= next_cur;
            addr_q  <= next_addr_q;
            dout_q  <= next_dout_q;
            oe_q    <= next_oe_q;
            sel_q   <= next_sel_q;
            ale_q   <= next_ale_q;
            wrl_q   <= next_wrl_q;
            wrh_q   <= next_wrh_q;
            rd_q    <= next_rd_q;
            grant_q <= next_grant_q;
            rsp_v   <= next_rsp_v;
            rsp_d   <= next_rsp_d;
            rsp_pend <= next_rsp_pend;
        end
    end

    // Pin drivers straight from flip-flops.
    assign o_addr                     = addr_q;
    assign o_data                     = dout_q;
    assign o_data_oe                  = oe_q;
    assign o_space_select_lines_n     = sel_q;
    assign o_address_latch_strobe     = ale_q;
    assign o_low_byte_write_strobe_n  = wrl_q;
    assign o_high_byte_write_strobe_n = wrh_q;
    assign o_read_strobe_n            = rd_q;
    assign o_bus_release_grant_n      = grant_q;
    assign o_rsp_valid                = rsp_v;
    assign o_rsp_rdata                = rsp_d;

    // Checks on the strobe relations.
    AST_HOLD_QUIET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_bus_release_grant_n |-> (o_read_strobe_n &&
            o_low_byte_write_strobe_n && o_high_byte_write_strobe_n)) // [R14]
        else $error("Strobe active while bus granted away.");
    AST_GRANT_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == EBSC_HOLD) |-> !o_bus_release_grant_n) // [R9]
        else $error("Grant high in hold state.");
    AST_HOLD_ENTRY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == EBSC_IDLE && !hold_s2) |=> (state == EBSC_HOLD)) // [R8]
        else $error("Hold request not honoured.");
    AST_READY_WAIT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == EBSC_WAIT && !rdy_s2) |=> (state == EBSC_WAIT)) // [R11]
        else $error("Cycle completed while ready low.");
    AST_READY_END: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == EBSC_WAIT && rdy_s2) |=> (state == EBSC_IDLE &&
            o_read_strobe_n)) // [R15]
        else $error("Access not ended after ready.");
    AST_ALE_FIRST: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_address_latch_strobe) |-> ##1 !o_address_latch_strobe
            ##[1:3] (!o_read_strobe_n || !o_low_byte_write_strobe_n ||
                     !o_high_byte_write_strobe_n)) // [R10]
        else $error("Address strobe not followed by access.");
    AST_SEP_EVEN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_single_strobe_mode && !o_high_byte_write_strobe_n && !c_word)
            |-> c_odd && o_low_byte_write_strobe_n) // [R2]
        else $error("High strobe on even byte write.");
    AST_SEP_ODD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_single_strobe_mode && !o_low_byte_write_strobe_n && !c_word)
            |-> !c_odd) // [R1]
        else $error("Low strobe on odd byte write.");
    AST_SINGLE_WR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_single_strobe_mode && state == EBSC_STROBE && c_write)
            |-> !o_low_byte_write_strobe_n &&
                (o_high_byte_write_strobe_n == !(c_word || c_odd))) // [R4]
        else $error("Single scheme strobes wrong.");
    AST_SEL_ONEHOT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == EBSC_STROBE) |-> $onehot(~o_space_select_lines_n)) // [R13]
        else $error("Space select not one-hot.");
    COV_READ: cover property (@(posedge i_clk_sys) $fell(o_read_strobe_n));
    COV_WAIT: cover property (@(posedge i_clk_sys) state == EBSC_WAIT);
    COV_HOLD: cover property (@(posedge i_clk_sys) state == EBSC_HOLD);
    COV_SINGLE: cover property (@(posedge i_clk_sys)
        i_single_strobe_mode && !o_low_byte_write_strobe_n);
endmodule : ebsc_top
`default_nettype wire

// >>> tb/ebsc_ext_mem.sv
// Behavioural model of the external memory that sits on the strobe bus.
`timescale 1ns/1ps
`default_nettype none
module ebsc_ext_mem (
    // Clock.
    input  wire logic                        i_clk_sys,
    // Bus driven by the device.
    input  wire logic                        i_ale,
    input  wire logic [ebsc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                        i_rd_n,
    // Number of wait cycles to ask for on the next access.
    input  wire logic [7:0]                  i_nwait,
    // Answers to the device.
    output logic [ebsc_pkg::DATA_W-1:0]      o_rdata,
    output logic                             o_ready_n
);
    import ebsc_pkg::*;
    logic [DATA_W-1:0] latched;          // Read data chosen at latch time.
    logic [7:0]        wait_cnt = 8'h00; // Wait cycles still owed.

    // Capture the address on the latch pulse and count the waits down.
    always @(posedge i_clk_sys) begin
        if (i_ale) begin
            latched  <= ~i_addr[DATA_W-1:0];
            wait_cnt <= (i_nwait == 8'h00) ? 8'h00 : i_nwait - 8'h01;
        end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end

    // Not ready is raised from the latch cycle on, since the device sees
    // this line two cycles late through its synchroniser.
    assign o_ready_n = !((i_ale && i_nwait != 8'h00) || wait_cnt != 8'h00);
    // Data only while the read strobe is low; otherwise a changed value,
    // so a late sample by the device cannot pass by luck.
    assign o_rdata = (i_rd_n == 1'b0) ? latched : ~latched;
endmodule // ebsc_ext_mem
`default_nettype wire

// >>> tb/external_bus_strobe_control_bench.sv
// Self-checking bench of the external bus strobe control block.
`timescale 1ns/1ps
`default_nettype none
module external_bus_strobe_control_bench;
    import ebsc_pkg::*;
    // One access and the strobe levels it should show.
    typedef struct packed {
        logic single; logic mux8; logic write; logic word;
        logic [1:0] space; logic [19:0] addr; logic [15:0] wdata;
        logic [7:0] nwait; logic low_n; logic high_n; logic rd_n;
    } ebsc_row_type;
    // Rows 4 to 7 use the single strobe scheme meant for 8-bit buses.
    localparam ebsc_row_type ROWS [8] = '{
        '{1'b0,1'b0,1'b1,1'b0,2'h0,20'h01234,16'h00a5,8'h00,1'b0,1'b1,1'b1},
        '{1'b0,1'b0,1'b1,1'b0,2'h1,20'h01235,16'h5a00,8'h01,1'b1,1'b0,1'b1},
        '{1'b0,1'b0,1'b1,1'b1,2'h2,20'h02468,16'hbeef,8'h03,1'b0,1'b0,1'b1},
        '{1'b0,1'b0,1'b0,1'b1,2'h3,20'h0fffe,16'h0000,8'h00,1'b1,1'b1,1'b0},
        '{1'b1,1'b0,1'b1,1'b0,2'h0,20'h10000,16'h0011,8'h00,1'b0,1'b1,1'b1},
        '{1'b1,1'b0,1'b1,1'b0,2'h1,20'h10001,16'h2200,8'h02,1'b0,1'b0,1'b1},
        '{1'b1,1'b0,1'b0,1'b0,2'h2,20'hfffff,16'h0000,8'h04,1'b1,1'b0,1'b0},
        '{1'b1,1'b1,1'b1,1'b0,2'h3,20'h000c4,16'h0033,8'h01,1'b0,1'b1,1'b1}};
    logic              i_clk_sys = 1'b0;
    logic              i_rst_n, i_single_strobe_mode, i_mux8_mode;
    logic              i_req_valid, o_req_ready, i_req_write, i_req_word;
    logic [1:0]        i_req_space;
    logic [19:0]       i_req_addr, o_addr;
    logic [15:0]       i_req_wdata, o_rsp_rdata, i_data, o_data, mem_data;
    logic              o_rsp_valid, o_data_oe, o_address_latch_strobe;
    logic [3:0]        o_space_select_lines_n;
    logic              o_low_byte_write_strobe_n, o_high_byte_write_strobe_n;
    logic              o_read_strobe_n, i_bus_release_request_n;
    logic              o_bus_release_grant_n, i_ready_n, stb_on;
    logic [7:0]        nwait;           // Waits the memory model asks for.
    int                ale_cnt = 0;     // Latch pulses seen so far.
    int                n_mismatch = 0;
    int                check_count = 0;

    always #25 i_clk_sys = ~i_clk_sys;
    // The shared data lines carry whoever drives them.
    assign i_data = o_data_oe ? o_data : mem_data;
    // High while any of the three strobes is active.
    always_comb stb_on = !(o_low_byte_write_strobe_n &&
                           o_high_byte_write_strobe_n && o_read_strobe_n);
    // Count latch pulses so that drained and blocked cycles can be judged.
    always @(posedge i_clk_sys) begin
        if (o_address_latch_strobe === 1'b1) begin
            ale_cnt <= ale_cnt + 1;
        end
    end

    ebsc_top dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_single_strobe_mode(i_single_strobe_mode), .i_mux8_mode(i_mux8_mode),
        .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
        .i_req_write(i_req_write), .i_req_word(i_req_word),
        .i_req_space(i_req_space), .i_req_addr(i_req_addr),
        .i_req_wdata(i_req_wdata), .o_rsp_valid(o_rsp_valid),
        .o_rsp_rdata(o_rsp_rdata), .o_addr(o_addr), .i_data(i_data),
        .o_data(o_data), .o_data_oe(o_data_oe),
        .o_space_select_lines_n(o_space_select_lines_n),
        .o_address_latch_strobe(o_address_latch_strobe),
        .o_low_byte_write_strobe_n(o_low_byte_write_strobe_n),
        .o_high_byte_write_strobe_n(o_high_byte_write_strobe_n),
        .o_read_strobe_n(o_read_strobe_n),
        .i_bus_release_request_n(i_bus_release_request_n),
        .o_bus_release_grant_n(o_bus_release_grant_n), .i_ready_n(i_ready_n));
    ebsc_ext_mem mem (.i_clk_sys(i_clk_sys), .i_ale(o_address_latch_strobe),
        .i_addr(o_addr), .i_rd_n(o_read_strobe_n), .i_nwait(nwait),
        .o_rdata(mem_data), .o_ready_n(i_ready_n));

    // Compare one value and count it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Wait at falling edges for a level; a hang counts as a mismatch.
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 1000) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (s !== v) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    // Hand one request to the queue for one cycle.
    task automatic send(input ebsc_row_type r);
        @(posedge i_clk_sys);
        i_single_strobe_mode <= r.single;
        i_mux8_mode <= r.mux8;
        i_req_write <= r.write;
        i_req_word <= r.word;
        i_req_space <= r.space;
        i_req_addr <= r.addr;
        i_req_wdata <= r.wdata;
        nwait <= r.nwait;
        i_req_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_req_valid <= 1'b0;
    endtask
    // Run one access and follow it on the bus.
    task automatic do_row(input ebsc_row_type r);
        int len;
        len = 0;
        send(r);
        wait_lvl(o_address_latch_strobe, 1'b1);
        chk(o_addr, r.addr);
        chk(o_space_select_lines_n, 4'(~(4'h1 << r.space)));
        if (r.mux8) begin
            chk({o_data_oe, o_data[7:0]}, {1'b1, r.addr[7:0]});
        end
        wait_lvl(stb_on, 1'b1);
        chk({o_low_byte_write_strobe_n, o_high_byte_write_strobe_n,
             o_read_strobe_n}, {r.low_n, r.high_n, r.rd_n});
        if (r.write) begin
            chk({o_data_oe, o_data}, {1'b1, r.wdata});
        end
        while (stb_on === 1'b1 && len < 100) begin
            @(negedge i_clk_sys);
            len++;
        end
        chk(len, STB_CYCLES + r.nwait);
        chk({o_space_select_lines_n, stb_on}, 5'h1e);
        if (!r.write) begin
            wait_lvl(o_rsp_valid, 1'b1);
            chk(o_rsp_rdata, 16'(~r.addr[15:0]));
        end
    endtask

    initial begin
        int acc;
        int base;
        i_rst_n = 1'b0;
        i_single_strobe_mode = 1'b0;
        i_mux8_mode = 1'b0;
        i_req_valid = 1'b0;
        i_req_write = 1'b0;
        i_req_word = 1'b0;
        i_req_space = 2'h0;
        i_req_addr = 20'h00000;
        i_req_wdata = 16'h0000;
        i_bus_release_request_n = 1'b1;
        nwait = 8'h00;
        acc = 0;
        repeat (3) @(negedge i_clk_sys);
        // Quiet bus while reset is held.
        chk({o_low_byte_write_strobe_n, o_high_byte_write_strobe_n,
             o_read_strobe_n, o_bus_release_grant_n, o_space_select_lines_n,
             o_address_latch_strobe, o_data_oe, o_rsp_valid}, 11'h7f8);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        foreach (ROWS[i]) begin
            do_row(ROWS[i]);
        end
        // Park the bus, then fill the queue while nothing may drain it.
        @(posedge i_clk_sys);
        i_bus_release_request_n <= 1'b0;
        wait_lvl(o_bus_release_grant_n, 1'b0);
        @(posedge i_clk_sys);
        base = ale_cnt;
        nwait <= 8'h02;
        i_req_valid <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge i_clk_sys);
            if (o_req_ready === 1'b1) begin
                acc++;
            end
            @(posedge i_clk_sys);
            i_req_addr <= 20'h00100 + 20'(2 * k);
        end
        i_req_valid <= 1'b0;
        @(negedge i_clk_sys);
        chk(acc, FIFO_DEPTH);
        chk({o_req_ready, stb_on, o_bus_release_grant_n}, 3'h0);
        chk(ale_cnt, base);
        // Release the bus; every queued access must now run, with waits.
        @(posedge i_clk_sys);
        i_bus_release_request_n <= 1'b1;
        wait_lvl(o_bus_release_grant_n, 1'b1);
        for (int n = 0; n < 1000 && ale_cnt - base < FIFO_DEPTH; n++) begin
            @(negedge i_clk_sys);
        end
        wait_lvl(stb_on, 1'b0);
        chk(ale_cnt - base, FIFO_DEPTH);
        // Reset in the middle of a strobe must drop every strobe at once.
        send(ROWS[2]);
        wait_lvl(stb_on, 1'b1);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({stb_on, o_space_select_lines_n, o_bus_release_grant_n}, 6'h1f);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        print_verdict();
    end
endmodule // external_bus_strobe_control_bench
`default_nettype wire
